// *** dsp_mul_consts.svh ***
// constants for the halfword multiply unit: opcodes, field positions, saturation values
`ifndef DSP_MUL_CONSTS_SVH
`define DSP_MUL_CONSTS_SVH

// instruction field positions
`define DSP_MAJOR_MSB      31
`define DSP_MAJOR_LSB      26
`define DSP_RT_MSB         25
`define DSP_RT_LSB         21
`define DSP_RS_MSB         20
`define DSP_RS_LSB         16
`define DSP_RD_MSB         15
`define DSP_RD_LSB         11
`define DSP_ACSEL_MSB      15
`define DSP_ACSEL_LSB      14

// opcode values
`define DSP_MAJOR_GROUP    6'h00
`define DSP_XF_POOL        6'h3C
`define DSP_MOVE_TO_LOW_HALF_MINOR     8'hC1
`define DSP_MULPH_MINOR    11'h02D
`define DSP_MULSPH_MINOR   11'h42D
`define DSP_MULEQ_MINOR    10'h025

// control register flag position and saturation values
`define DSP_OUFLAG_BIT     21
`define DSP_SAT_POS16      16'h7FFF
`define DSP_SAT_NEG16      16'h8000
`define DSP_Q15_MINUS_ONE  16'h8000
`define DSP_Q31_MAX        32'h7FFFFFFF

// accumulator layout and reset values
`define DSP_ACC_HI_MSB     63
`define DSP_ACC_HI_LSB     32
`define DSP_ACC_RST        64'h0000000000000000
`define DSP_WORD_RST       32'h00000000

`endif

// *** dsp_mul_pkg.sv ***
// types and the shared instruction decoder of the halfword multiply unit
`include "dsp_mul_consts.svh"

package dsp_mul_pkg;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MOVE_TO_LOW_HALF = 3'h1,
    OP_MULW = 3'h2,
    OP_MULS = 3'h3,
    OP_MULQ = 3'h4
  } dsp_op_t;

  // gray along idle -> send -> wait; wait -> idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_WAIT = 2'h3
  } core_state_t;

  // classify one instruction word; anything else is reserved
  function automatic dsp_op_t decode_op(input logic [31:0] instr);
    dsp_op_t op;
    op = OP_NONE;
    if (instr[`DSP_MAJOR_MSB:`DSP_MAJOR_LSB] == `DSP_MAJOR_GROUP) begin
      if (instr[13:6] == `DSP_MOVE_TO_LOW_HALF_MINOR && instr[5:0] == `DSP_XF_POOL && instr[25:21] == 5'h00) begin
        op = OP_MOVE_TO_LOW_HALF;
      end else if (instr[10:0] == `DSP_MULPH_MINOR) begin
        op = OP_MULW;
      end else if (instr[10:0] == `DSP_MULSPH_MINOR) begin
        op = OP_MULS;
      end else if (instr[10] == 1'b0 && instr[9:0] == `DSP_MULEQ_MINOR) begin
        op = OP_MULQ;
      end
    end
    return op;
  endfunction : decode_op

endpackage : dsp_mul_pkg

// *** dsp_link_if.sv ***
// request/response link between the core pipeline and the multiply unit
interface dsp_link_if;
  logic        req_valid;
  logic        req_ready;
  logic [31:0] req_instr;
  logic [31:0] req_rs;
  logic [31:0] req_rt;
  logic        req_enable;
  logic        rsp_valid;
  logic        rsp_gpr_we;
  logic [4:0]  rsp_rd;
  logic [31:0] rsp_data;
  logic        rsp_exc_ri;
  logic        rsp_exc_dis;

  modport core (
    output req_valid, req_instr, req_rs, req_rt, req_enable,
    input  req_ready, rsp_valid, rsp_gpr_we, rsp_rd, rsp_data, rsp_exc_ri, rsp_exc_dis
  );

  modport unit (
    input  req_valid, req_instr, req_rs, req_rt, req_enable,
    output req_ready, rsp_valid, rsp_gpr_we, rsp_rd, rsp_data, rsp_exc_ri, rsp_exc_dis
  );
endinterface : dsp_link_if

// *** hw_lane_mul.sv ***
// one signed halfword lane multiply with optional 16-bit saturation
module hw_lane_mul
  import dsp_mul_pkg::*;
#(
  parameter int W = 16
) (
  // operands
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  input  wire logic         i_sat,
  // result
  output logic      [W-1:0] o_res,
  output logic              o_ovf
);

  // saturation constants are 16 bits wide
  if (W != 16) begin : g_bad_width
    $error("hw_lane_mul supports only W = 16");
  end

  logic signed [2*W-1:0] prod;
  logic                  too_big;
  logic                  too_small;

  // full signed intermediate product of the lane
  assign prod      = $signed(i_a) * $signed(i_b);
  assign too_big   = prod > $signed({{W{1'b0}}, `DSP_SAT_POS16});
  assign too_small = prod < $signed({{W{1'b1}}, `DSP_SAT_NEG16});
  assign o_ovf     = too_big | too_small;

  // wrap keeps the low half, saturate clamps by sign
  always_comb begin
    if (i_sat && too_big) begin
      o_res = `DSP_SAT_POS16;
    end else if (i_sat && too_small) begin
      o_res = `DSP_SAT_NEG16;
    end else begin
      o_res = prod[W-1:0];
    end
  end

endmodule : hw_lane_mul

// *** dsp_mul_unit.sv ***
// device end: decode, halfword/fractional multiply, accumulators and overflow flag
`include "dsp_mul_consts.svh"
// one request per cycle; every answer comes exactly one cycle later
// multiplies never touch the accumulators; only move-to-low writes them
// the overflow flag is sticky: software clears it, hardware only sets it

module dsp_mul_unit
  import dsp_mul_pkg::*;
#(
  parameter int NUM_ACC = 4
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  // link to the core
  dsp_link_if.unit         lnk,
  // accumulator observation
  input  wire logic [1:0]  i_acc_sel,
  output logic      [63:0] o_acc_data,
  // overflow flag of the extension control register
  input  wire logic        i_ouflag_wr,
  input  wire logic        i_ouflag_val,
  output logic      [31:0] o_ctl_word
);

  // the selector field is two bits wide
  if (NUM_ACC != 4) begin : g_bad_acc
    $error("dsp_mul_unit needs exactly four accumulators");
  end

  // the low-half write below assumes the high half starts at bit 32
  if (`DSP_ACC_HI_MSB != 63 || `DSP_ACC_HI_LSB != 32) begin : g_bad_layout
    $error("dsp_mul_unit expects the high half at bits 63..32");
  end

  // architectural state: four accumulators and the overflow flag
  logic [63:0] acc_q [NUM_ACC];
  logic        ouflag_q;

  // decode of the request on the link
  dsp_op_t     op;
  logic        take;
  logic        run;
  logic [1:0]  acc_sel;

  // paired halfword lanes
  logic [31:0] pair_res;
  logic [1:0]  lane_ovf;

  // fractional path on the upper halfwords
  logic [15:0] q_a;
  logic [15:0] q_b;
  logic        q_sat;
  logic [31:0] q_prod;
  logic [31:0] q_res;
  logic        set_flag;

  // registered answer on the link
  logic        rsp_valid_q;
  logic        rsp_we_q;
  logic [4:0]  rsp_rd_q;
  logic [31:0] rsp_data_q;
  logic        rsp_ri_q;
  logic        rsp_dis_q;

  // single-cycle datapath, so the unit can always take a request
  // a multi-cycle multiplier would have to drop ready while busy
  assign lnk.req_ready = 1'b1;
  assign take          = lnk.req_valid;
  assign op            = decode_op(lnk.req_instr);
  // recognised and enabled: only then may state change
  assign run           = take && lnk.req_enable && (op != OP_NONE);
  // the selector overlaps the destination field; only move-to-low reads it
  assign acc_sel       = lnk.req_instr[`DSP_ACSEL_MSB:`DSP_ACSEL_LSB];

  // two lanes, upper and lower halfwords of each source
  // lane 1 pairs the upper halfwords, lane 0 the lower ones
  for (genvar g = 0; g < 2; g++) begin : g_lane
    hw_lane_mul #(
      .W (16)
    ) u_lane (
      .i_a   (lnk.req_rs[16*g +: 16]),
      .i_b   (lnk.req_rt[16*g +: 16]),
      .i_sat (op == OP_MULS),
      .o_res (pair_res[16*g +: 16]),
      .o_ovf (lane_ovf[g])
    );
  end

  // q15 x q15 of the upper halves, doubled into q31
  assign q_a    = lnk.req_rs[31:16];
  assign q_b    = lnk.req_rt[31:16];
  assign q_sat  = (q_a == `DSP_Q15_MINUS_ONE) && (q_b == `DSP_Q15_MINUS_ONE);
  // operands widened first so the product is formed at its full 32-bit width
  assign q_prod = $signed({{16{q_a[15]}}, q_a}) * $signed({{16{q_b[15]}}, q_b});
  // minus one squared is the only case that does not fit
  assign q_res  = q_sat ? `DSP_Q31_MAX : {q_prod[30:0], 1'b0};

  // only the saturating forms report overflow
  // the wrapping form may overflow too, but it reports nothing
  assign set_flag = run && (((op == OP_MULS) && (|lane_ovf)) || ((op == OP_MULQ) && q_sat));

  // accumulators: only move-to-low writes them; multiplies leave all four as they were
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= `DSP_ACC_RST;
      end
    end else if (run && op == OP_MOVE_TO_LOW_HALF) begin
      // low half only, high half bits 63..32 stay put
      acc_q[acc_sel][`DSP_ACC_HI_LSB-1:0] <= lnk.req_rs;
    end
    // ac0 may legally hold anything after a register-target multiply; keeping it
    // unchanged is the cheapest choice and leaves an unread legacy result intact
    // no write path for multiplies keeps ac1..ac3 intact
  end

  // overflow flag: hardware only sets it, a set beats a software write
  // a clear landing in the same cycle as a saturation loses, so no event is missed
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ouflag_q <= 1'b0;
    end else if (set_flag) begin
      ouflag_q <= 1'b1;
    end else if (i_ouflag_wr) begin
      ouflag_q <= i_ouflag_val;
    end
  end

  // answer pulses, one cycle after the request is taken
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rsp_valid_q <= 1'b0;
      rsp_ri_q    <= 1'b0;
      rsp_dis_q   <= 1'b0;
    end else begin
      rsp_valid_q <= take;
      // no arithmetic trap exists: only reserved or disabled
      rsp_ri_q    <= take && (op == OP_NONE);
      rsp_dis_q   <= take && (op != OP_NONE) && !lnk.req_enable;
    end
  end

  // result word and its target; the word holds when nothing new is computed
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rsp_we_q    <= 1'b0;
      rsp_rd_q    <= 5'h00;
      rsp_data_q  <= `DSP_WORD_RST;
    end else begin
      rsp_we_q    <= run && (op != OP_MOVE_TO_LOW_HALF);
      rsp_rd_q    <= lnk.req_instr[`DSP_RD_MSB:`DSP_RD_LSB];
      if (run && op == OP_MULQ) begin
        rsp_data_q <= q_res;
      end else if (run && (op == OP_MULW || op == OP_MULS)) begin
        rsp_data_q <= pair_res;
      end
    end
  end

  // link outputs come straight from the answer registers
  assign lnk.rsp_valid   = rsp_valid_q;
  assign lnk.rsp_gpr_we  = rsp_we_q;
  assign lnk.rsp_rd      = rsp_rd_q;
  assign lnk.rsp_data    = rsp_data_q;
  assign lnk.rsp_exc_ri  = rsp_ri_q;
  assign lnk.rsp_exc_dis = rsp_dis_q;

  // registered accumulator read port
  // one cycle of latency keeps the 64-bit mux out of the observer's path
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_acc_data <= `DSP_ACC_RST;
    end else begin
      o_acc_data <= acc_q[i_acc_sel];
    end
  end

  // control word shows only the overflow flag; other bits read zero
  // a fuller control register would merge its other fields here
  always_comb begin
    o_ctl_word                  = `DSP_WORD_RST;
    o_ctl_word[`DSP_OUFLAG_BIT] = ouflag_q;
  end

endmodule : dsp_mul_unit

// *** dsp_core_end.sv ***
// core end: issues one instruction at a time and returns the unit's answer
`include "dsp_mul_consts.svh"

module dsp_core_end
  import dsp_mul_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_srst,
  // link to the unit
  dsp_link_if.core         lnk,
  // issue side
  input  wire logic        i_issue,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_rs_data,
  input  wire logic [31:0] i_rt_data,
  input  wire logic        i_ext_enable,
  input  wire logic        i_ac0_unread,
  // result side
  output logic             o_busy,
  output logic             o_done,
  output logic             o_rd_we,
  output logic      [4:0]  o_rd_idx,
  output logic      [31:0] o_rd_data,
  output logic             o_exc_ri,
  output logic             o_exc_dis,
  output logic             o_ac0_clobbered
);

  core_state_t state_q;
  logic [31:0] instr_q;
  logic [31:0] rs_q;
  logic [31:0] rt_q;
  logic        en_q;
  logic        hazard;

  // hold a move-to-low into ac0 while a legacy result is still unread
  assign hazard = (decode_op(instr_q) == OP_MOVE_TO_LOW_HALF) &&
                  (instr_q[`DSP_ACSEL_MSB:`DSP_ACSEL_LSB] == 2'h0) && i_ac0_unread;

  // operands pass as given; their format is the software's concern
  assign lnk.req_valid  = (state_q == ST_SEND) && !hazard;
  assign lnk.req_instr  = instr_q;
  assign lnk.req_rs     = rs_q;
  assign lnk.req_rt     = rt_q;
  assign lnk.req_enable = en_q;
  assign o_busy         = (state_q != ST_IDLE);

  // issue sequencer; a new issue while busy is ignored
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_issue) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (lnk.req_valid && lnk.req_ready) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (lnk.rsp_valid) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // request capture at issue
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      instr_q <= `DSP_WORD_RST;
      rs_q    <= `DSP_WORD_RST;
      rt_q    <= `DSP_WORD_RST;
      en_q    <= 1'b0;
    end else if (state_q == ST_IDLE && i_issue) begin
      instr_q <= i_instr;
      rs_q    <= i_rs_data;
      rt_q    <= i_rt_data;
      en_q    <= i_ext_enable;
    end
  end

  // result capture; done and clobber are one-cycle pulses
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_done          <= 1'b0;
      o_rd_we         <= 1'b0;
      o_rd_idx        <= 5'h00;
      o_rd_data       <= `DSP_WORD_RST;
      o_exc_ri        <= 1'b0;
      o_exc_dis       <= 1'b0;
      o_ac0_clobbered <= 1'b0;
    end else begin
      o_done          <= (state_q == ST_WAIT) && lnk.rsp_valid;
      // register-target multiply: software treats ac0 as lost
      o_ac0_clobbered <= (state_q == ST_WAIT) && lnk.rsp_valid && lnk.rsp_gpr_we;
      if (state_q == ST_WAIT && lnk.rsp_valid) begin
        o_rd_we   <= lnk.rsp_gpr_we;
        o_rd_idx  <= lnk.rsp_rd;
        o_rd_data <= lnk.rsp_data;
        o_exc_ri  <= lnk.rsp_exc_ri;
        o_exc_dis <= lnk.rsp_exc_dis;
      end
    end
  end

endmodule : dsp_core_end

// *** dsp_link_sva.sv ***
// assertion checker for the link between the core end and the multiply unit
module dsp_link_sva (
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_srst,
  // link signals
  input wire logic        req_valid,
  input wire logic [31:0] req_instr,
  input wire logic [31:0] req_rs,
  input wire logic [31:0] req_rt,
  input wire logic        req_enable,
  input wire logic        rsp_valid,
  input wire logic        rsp_gpr_we,
  input wire logic [4:0]  rsp_rd,
  input wire logic [31:0] rsp_data,
  input wire logic        rsp_exc_ri,
  input wire logic        rsp_exc_dis
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  // clamp one lane product into 16 signed bits
  function automatic logic [15:0] sat16(input logic signed [31:0] p);
    return (p > 32'sh00007FFF) ? 16'h7FFF : (p < -32'sh00008000) ? 16'h8000 : p[15:0];
  endfunction : sat16

  // reference lane products and decode, kept apart from the design decoder
  logic signed [31:0] ph;
  logic signed [31:0] pl;
  logic [31:0]        ew;
  logic [31:0]        es;
  logic [31:0]        eq;
  logic [4:0]         rdf;
  logic               kl;
  logic               kw;
  logic               ks;
  logic               kq;
  logic               km;
  logic               go;
  assign ph  = $signed(req_rs[31:16]) * $signed(req_rt[31:16]);
  assign pl  = $signed(req_rs[15:0]) * $signed(req_rt[15:0]);
  assign ew  = {ph[15:0], pl[15:0]};
  assign es  = {sat16(ph), sat16(pl)};
  assign eq  = (req_rs[31:16] == 16'h8000 && req_rt[31:16] == 16'h8000) ? 32'h7FFFFFFF : {ph[30:0], 1'b0};
  assign rdf = req_instr[15:11];
  assign kl  = req_instr[31:21] == 11'h000 && req_instr[13:0] == {8'hC1, 6'h3C};
  assign kw  = req_instr[31:26] == 6'h00 && req_instr[10:0] == 11'h02D;
  assign ks  = req_instr[31:26] == 6'h00 && req_instr[10:0] == 11'h42D;
  assign kq  = req_instr[31:26] == 6'h00 && req_instr[10:0] == 11'h025;
  assign km  = kw || ks || kq;
  assign go  = req_valid && req_enable;

  AST_ANSWER: assert property (req_valid |=> rsp_valid)
    else $error("no answer one cycle after a request");
  AST_NO_SPUR: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without a request");
  AST_RSV: assert property (req_valid && !(kl || km) |=> rsp_exc_ri && !rsp_exc_dis)
    else $error("unknown word not reserved");
  AST_DIS: assert property (req_valid && !req_enable && (kl || km) |=> rsp_exc_dis && !rsp_gpr_we)
    else $error("disabled instruction not trapped");
  AST_MOVE_TO_LOW_HALF: assert property (go && kl |=> !rsp_gpr_we && !rsp_exc_ri && !rsp_exc_dis)
    else $error("move to low misbehaved on the link");
  AST_WRAP: assert property (go && kw |=> rsp_gpr_we && rsp_data == $past(ew))
    else $error("wrapping paired product wrong");
  AST_SAT: assert property (go && ks |=> rsp_gpr_we && rsp_data == $past(es))
    else $error("saturating paired product wrong");
  AST_FRAC: assert property (go && kq |=> rsp_data == $past(eq))
    else $error("fractional product wrong");
  AST_DEST: assert property (go && km |=> rsp_rd == $past(rdf) && !rsp_exc_ri)
    else $error("destination field wrong");

  // main scenarios
  cover property (go && kq);
  cover property (req_valid && !req_enable && km);
  cover property (go && kl && req_instr[15:14] == 2'h3);
endmodule : dsp_link_sva

// *** dsp_halfword_multiply_unit_tb_top.sv ***
// self-checking bench for the multiply unit joined to its core end
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
module dsp_halfword_multiply_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_sys_clk    = 1'b0;
  logic        i_srst       = 1'b1;
  logic        i_issue      = 1'b0;
  logic [31:0] i_instr      = 32'h00000000;
  logic [31:0] i_rs_data    = 32'h00000000;
  logic [31:0] i_rt_data    = 32'h00000000;
  logic        i_ext_enable = 1'b1;
  logic        i_ac0_unread = 1'b0;
  logic [1:0]  i_acc_sel    = 2'h0;
  logic        i_ouflag_wr  = 1'b0;
  logic        o_busy, o_done, o_rd_we, o_exc_ri, o_exc_dis, o_clob;
  logic [4:0]  o_rd_idx;
  logic [31:0] o_rd_data, o_ctl_word;
  logic [63:0] o_acc_data;
  int          failures     = 0;
  int          comparisons  = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  dsp_link_if lnk ();
  dsp_mul_unit #(.NUM_ACC(4)) dsp_mul_unit_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .lnk(lnk),
    .i_acc_sel(i_acc_sel), .o_acc_data(o_acc_data), .i_ouflag_wr(i_ouflag_wr), .i_ouflag_val(1'b0),
    .o_ctl_word(o_ctl_word));
  dsp_core_end dsp_core_end_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .lnk(lnk), .i_issue(i_issue),
    .i_instr(i_instr), .i_rs_data(i_rs_data), .i_rt_data(i_rt_data), .i_ext_enable(i_ext_enable),
    .i_ac0_unread(i_ac0_unread), .o_busy(o_busy), .o_done(o_done), .o_rd_we(o_rd_we), .o_rd_idx(o_rd_idx),
    .o_rd_data(o_rd_data), .o_exc_ri(o_exc_ri), .o_exc_dis(o_exc_dis), .o_ac0_clobbered(o_clob));
  dsp_link_sva dsp_link_sva_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .req_valid(lnk.req_valid),
    .req_instr(lnk.req_instr), .req_rs(lnk.req_rs), .req_rt(lnk.req_rt), .req_enable(lnk.req_enable),
    .rsp_valid(lnk.rsp_valid), .rsp_gpr_we(lnk.rsp_gpr_we), .rsp_rd(lnk.rsp_rd), .rsp_data(lnk.rsp_data),
    .rsp_exc_ri(lnk.rsp_exc_ri), .rsp_exc_dis(lnk.rsp_exc_dis));

  task tally_and_finish;
    $display("counts: %0d compared, %0d bad", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [31:0] move_to_low_half(input logic [1:0] s);
    return {11'h000, 5'h01, s, 8'hC1, 6'h3C};
  endfunction : move_to_low_half

  function automatic logic [31:0] mul(input logic [10:0] m);
    return {6'h00, 5'h02, 5'h01, 5'h07, m};
  endfunction : mul

  // issue one instruction and wait a bounded time for done
  task run(input logic [31:0] ins, input logic [31:0] rs, input logic [31:0] rt, input logic en);
    int n;
    @(posedge i_sys_clk);
    i_issue <= 1'b1;
    i_instr <= ins;
    i_rs_data <= rs;
    i_rt_data <= rt;
    i_ext_enable <= en;
    @(posedge i_sys_clk);
    i_issue <= 1'b0;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end while (o_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      tally_and_finish();
    end
  endtask : run

  // read one accumulator through the one-cycle observation port
  task acc(input logic [1:0] s, input logic [63:0] e);
    @(posedge i_sys_clk);
    i_acc_sel <= s;
    @(posedge i_sys_clk);
    #1;
    `CHK("acc", e, o_acc_data)
  endtask : acc

  // accumulators one to three still hold what move-to-low put there
  task keep;
    for (int i = 1; i < 4; i++) acc(i[1:0], {32'h00000000, 32'hA5A50000 + i});
  endtask : keep

  // software clear of the overflow flag
  task clr;
    @(posedge i_sys_clk);
    i_ouflag_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_ouflag_wr <= 1'b0;
    #1;
    `CHK("flag", 1'b0, o_ctl_word[21])
  endtask : clr

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    for (int i = 0; i < 4; i++) run(move_to_low_half(i[1:0]), 32'hA5A50000 + i, 32'h00000000, 1'b1);
    acc(2'h0, 64'h00000000A5A50000);
    keep();
    $display("test move to low done");
    run(mul(11'h02D), 32'h7FFF8000, 32'h0002FFFF, 1'b1);
    `CHK("wrap", 32'hFFFE8000, o_rd_data)
    `CHK("rd", 5'h07, o_rd_idx)
    `CHK("we", 1'b1, o_rd_we)
    `CHK("clob", 1'b1, o_clob)
    `CHK("flag", 1'b0, o_ctl_word[21])
    keep();
    $display("test wrap done");
    run(mul(11'h42D), 32'h7FFF8000, 32'h0002FFFF, 1'b1);
    `CHK("sat", 32'h7FFF7FFF, o_rd_data)
    `CHK("flag", 1'b1, o_ctl_word[21])
    run(mul(11'h42D), 32'h80000100, 32'h00020003, 1'b1);
    `CHK("satneg", 32'h80000300, o_rd_data)
    $display("test saturate done");
    run(mul(11'h025), 32'h40001234, 32'h40005678, 1'b1);
    `CHK("frac", 32'h20000000, o_rd_data)
    `CHK("flag", 1'b1, o_ctl_word[21])
    clr();
    // a software clear in the very cycle of the saturation must lose
    fork
      run(mul(11'h025), 32'h80000000, 32'h80000000, 1'b1);
      begin
        repeat (2) @(posedge i_sys_clk);
        i_ouflag_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_ouflag_wr <= 1'b0;
      end
    join
    `CHK("fracmax", 32'h7FFFFFFF, o_rd_data)
    `CHK("flag", 1'b1, o_ctl_word[21])
    keep();
    $display("test fractional done");
    clr();
    run(mul(11'h42D), 32'h7FFF8000, 32'h0002FFFF, 1'b0);
    `CHK("dis", 1'b1, o_exc_dis)
    `CHK("we_dis", 1'b0, o_rd_we)
    `CHK("flag", 1'b0, o_ctl_word[21])
    run(move_to_low_half(2'h1), 32'h12345678, 32'h00000000, 1'b0);
    keep();
    run(32'hFC000000, 32'h00000000, 32'h00000000, 1'b1);
    `CHK("ri", 1'b1, o_exc_ri)
    `CHK("ri_dis", 1'b0, o_exc_dis)
    $display("test exceptions done");
    // an unread legacy result must hold back a write to accumulator zero
    @(posedge i_sys_clk);
    i_ac0_unread <= 1'b1;
    fork
      run(move_to_low_half(2'h0), 32'h13572468, 32'h00000000, 1'b1);
      begin
        repeat (8) @(posedge i_sys_clk);
        #1;
        `CHK("held", 1'b1, o_busy)
        @(posedge i_sys_clk);
        i_ac0_unread <= 1'b0;
      end
    join
    `CHK("clob_move_to_low_half", 1'b0, o_clob)
    acc(2'h0, 64'h0000000013572468);
    $display("test hazard done");
    tally_and_finish();
  end
endmodule : dsp_halfword_multiply_unit_tb_top
